// ### icb_pkg.sv
// Constants shared by the configuration and control bank.
package icb_pkg;

    // ========================================================
    // Clock and times
    localparam int CLK_MHZ = 125;
    localparam longint TB_FAST_PS = 64'd610_350_000;
    localparam longint TB_SLOW_PS = 64'd18_921_000_000;
    localparam longint HALF_SEC_MS = 64'd500;
    localparam longint DRDY_MIN_NS = 64'd100_000;
    localparam longint DRDY_MAX_NS = 64'd200_000;
    localparam int TB_FAST_CYCLES = int'((TB_FAST_PS * CLK_MHZ) / 64'd1_000_000);
    localparam int TB_SLOW_CYCLES = int'((TB_SLOW_PS * CLK_MHZ) / 64'd1_000_000);
    localparam int HALF_SEC_CYCLES = int'(HALF_SEC_MS * CLK_MHZ * 64'd1000);
    localparam int DRDY_CYCLES = int'((DRDY_MIN_NS * CLK_MHZ + 64'd999) / 64'd1000);

    // ========================================================
    // Byte addresses of the lower bytes
    localparam logic [6:0] ADDR_DAC = 7'h30;
    localparam logic [6:0] ADDR_GPIO = 7'h32;
    localparam logic [6:0] ADDR_MISC = 7'h34;
    localparam logic [6:0] ADDR_PERIOD = 7'h36;
    localparam logic [6:0] ADDR_RANGE = 7'h38;
    localparam logic [6:0] ADDR_SLEEP = 7'h3a;
    localparam logic [6:0] ADDR_GLOBAL = 7'h3e;

    // ========================================================
    // Reset values
    localparam logic [15:0] RST_MISC = 16'h0006;
    localparam logic [7:0] RST_PERIOD = 8'h01;
    localparam logic [2:0] RST_RANGE = 3'h4;
    localparam logic [2:0] RST_FILTER = 3'h2;

    // ========================================================
    // Field positions and codes
    localparam int PERIOD_TB_BIT = 7;
    localparam logic [7:0] LOW_POWER_MIN = 8'h0a;
    localparam logic [7:0] EXT_CLK_PERIOD = 8'h00;
    localparam int SLEEP_FOREVER_BIT = 0;
    localparam int MISC_DRDY_EN = 2;
    localparam int MISC_DRDY_POL = 1;
    localparam int MISC_DRDY_LINE = 0;
    localparam int MISC_ORIGIN = 6;
    localparam int MISC_BIAS = 7;
    localparam int MISC_ST_POS = 8;
    localparam int MISC_ST_NEG = 9;
    localparam int MISC_SELF_TEST = 10;
    localparam int MISC_MEM_TEST = 11;
    localparam int GLOBAL_DAC_LATCH = 2;
    localparam int EXT_CLK_LINE = 3;
    localparam logic [2:0] RANGE_HALF = 3'h2;
    localparam logic [2:0] RANGE_QUARTER = 3'h1;
    localparam logic [2:0] MIN_EXP_HALF = 3'h2;
    localparam logic [2:0] MIN_EXP_QUARTER = 3'h4;

endpackage

// ### icb_timer_if.sv
// Signals between the register bank and its sample period timer.
`timescale 1ns/1ps
`default_nettype none

interface icb_timer_if;
    logic [7:0] period;
    logic       ext_mode;
    logic       ext_edge;
    logic       sleep_forever;
    logic       sleep_load;
    logic [7:0] sleep_count;
    logic       wake;
    logic       sample_tick;
    logic       sleeping;

    modport bank (
        output period, ext_mode, ext_edge, sleep_forever, sleep_load, sleep_count, wake,
        input  sample_tick, sleeping
    );
    modport timer (
        input  period, ext_mode, ext_edge, sleep_forever, sleep_load, sleep_count, wake,
        output sample_tick, sleeping
    );
endinterface

`default_nettype wire

// ### icb_sample_timer.sv
// Sample period generator and sleep timer.
`timescale 1ns/1ps
`default_nettype none

module icb_sample_timer
    import icb_pkg::*;
#(
    parameter int TB_FAST  = TB_FAST_CYCLES,
    parameter int TB_SLOW  = TB_SLOW_CYCLES,
    parameter int HALF_SEC = HALF_SEC_CYCLES
) (
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  ce,
    icb_timer_if.timer t
);

    logic [31:0] base_cnt;
    logic [6:0]  inc_cnt;
    logic [31:0] half_cnt;
    logic [7:0]  sleep_left;
    logic        sleep_inf;
    logic [31:0] tb_len;

    assign tb_len = t.period[PERIOD_TB_BIT] ? 32'(TB_SLOW) : 32'(TB_FAST);
    assign t.sleeping = sleep_inf | (sleep_left != 8'h00);

    // ========================================================
    // Sleep control
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sleep_inf <= 1'b0;
        end else if (ce) begin
            if (t.wake) begin
                sleep_inf <= 1'b0;
            end else if (t.sleep_forever) begin
                sleep_inf <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sleep_left <= 8'h00;
            half_cnt   <= 32'h0;
        end else if (ce) begin
            if (t.sleep_load) begin
                sleep_left <= t.sleep_count;
                half_cnt   <= 32'h0;
            end else if (sleep_left != 8'h00) begin
                if (half_cnt == 32'(HALF_SEC - 1)) begin
                    half_cnt   <= 32'h0;
                    sleep_left <= sleep_left - 8'h01;
                end else begin
                    half_cnt <= half_cnt + 32'h1;
                end
            end
        end
    end

    // ========================================================
    // Sample period: time base times increment plus one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            base_cnt      <= 32'h0;
            inc_cnt       <= 7'h00;
            t.sample_tick <= 1'b0;
        end else if (ce) begin
            t.sample_tick <= 1'b0;
            if (t.sleeping) begin
                base_cnt <= 32'h0;
                inc_cnt  <= 7'h00;
            end else if (t.ext_mode) begin
                t.sample_tick <= t.ext_edge;
                base_cnt      <= 32'h0;
                inc_cnt       <= 7'h00;
            end else if (base_cnt >= tb_len - 32'h1) begin
                base_cnt <= 32'h0;
                if (inc_cnt >= t.period[6:0]) begin
                    inc_cnt       <= 7'h00;
                    t.sample_tick <= 1'b1;
                end else begin
                    inc_cnt <= inc_cnt + 7'h01;
                end
            end else begin
                base_cnt <= base_cnt + 32'h1;
            end
        end
    end

endmodule

`default_nettype wire

// ### icb_config_bank.sv
// Configuration and control register bank of a six-axis inertial sensor.
//
// Summary of operation
// - Period bit 7 picks the time base, fast when clear, slow when set.
// - Sample period equals time base times the increment count plus one.
// - A period value of 0x0a or more selects low power mode.
// - Sleep bit 8 sleeps until chip select falls, or reset.
// - Sleep bits 7 to 0 give a timed sleep in half seconds.
// - Outputs are smoothed by two cascaded moving-average stages.
// - Each stage has two to the power of filter bits 2 to 0 taps.
// - Range bits 10 to 8 select the full, half or quarter gyro range.
// - Reduced ranges force a minimum filter exponent of two or four.
// - Aux line function priority: misc control, then alarm, then general I/O.
// - General I/O bits 3 to 0 set directions, bits 11 to 8 levels.
// - Line four as input with period zero samples on the host's clock.
// - Misc bits 2 to 0 enable, set polarity and route data ready.
// - Each data ready pulse lasts between 100 and 200 microseconds.
// - Misc bit 10 starts the internal self-test and clears when done.
// - Misc bit 11 starts the memory checksum test and clears when done.
// - Misc bits 9 and 8 apply negative and positive manual stimulus.
// - Misc bits 7 and 6 enable bias compensation and origin alignment.
// - A 12-bit offset-binary code drives the auxiliary DAC.
// - Global command bit 2 moves the staged code into the DAC at once.
// - Each register holds two bytes, the upper byte at address plus one.
// - Global command bits start on a one and read back zero after.
`timescale 1ns/1ps
`default_nettype none

module icb_config_bank
    import icb_pkg::*;
#(
    parameter int TB_FAST  = TB_FAST_CYCLES,
    parameter int TB_SLOW  = TB_SLOW_CYCLES,
    parameter int HALF_SEC = HALF_SEC_CYCLES,
    parameter int DRDY_LEN = DRDY_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        reg_wr,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    input  wire logic        cs_n,
    input  wire logic [3:0]  aux_in,
    output logic [3:0]       aux_out,
    output logic [3:0]       aux_oe,
    input  wire logic        alarm_en,
    input  wire logic        alarm_line,
    input  wire logic        alarm_level,
    output logic             sample_tick,
    output logic             sleeping,
    output logic             low_power,
    output logic [2:0]       gyro_range,
    output logic [2:0]       filter_exp,
    output logic             bias_comp_en,
    output logic             origin_align_en,
    output logic             stim_neg,
    output logic             stim_pos,
    output logic             self_test_start,
    input  wire logic        self_test_done,
    output logic             mem_test_start,
    input  wire logic        mem_test_done,
    output logic [11:0]      dac_code
);

    icb_timer_if tif ();

    logic [11:0] dac_stage;
    logic [3:0]  gpio_dir;
    logic [3:0]  gpio_level;
    logic [15:0] misc;
    logic [7:0]  period;
    logic [2:0]  range_sel;
    logic [2:0]  filt;
    logic [8:0]  sleep_val;
    logic [1:0]  cs_sync;
    logic        cs_prev;
    logic [1:0]  l4_sync;
    logic        l4_prev;
    logic [31:0] drdy_cnt;
    logic        drdy_pulse;
    logic        wr_lo;
    logic        wr_hi;
    logic [6:0]  base;

    // Lowest filter exponent allowed for a given range code.
    function automatic logic [2:0] min_exp(input logic [2:0] rng);
        if (rng == RANGE_QUARTER) begin
            min_exp = MIN_EXP_QUARTER;
        end else if (rng == RANGE_HALF) begin
            min_exp = MIN_EXP_HALF;
        end else begin
            min_exp = 3'h0;
        end
    endfunction

    function automatic logic [2:0] clamp_exp(input logic [2:0] rng, input logic [2:0] e);
        clamp_exp = (e < min_exp(rng)) ? min_exp(rng) : e;
    endfunction

    // ========================================================
    // Byte decode
    assign base  = {reg_addr[6:1], 1'b0};
    assign wr_lo = reg_wr & ~reg_addr[0];
    assign wr_hi = reg_wr & reg_addr[0];

    // ========================================================
    // Pin synchronisers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs_sync <= 2'b11;
            cs_prev <= 1'b1;
            l4_sync <= 2'b00;
            l4_prev <= 1'b0;
        end else if (ce) begin
            cs_sync <= {cs_sync[0], cs_n};
            cs_prev <= cs_sync[1];
            l4_sync <= {l4_sync[0], aux_in[EXT_CLK_LINE]};
            l4_prev <= l4_sync[1];
        end
    end

    // ========================================================
    // Sample period and sleep registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            period <= RST_PERIOD;
        end else if (ce && wr_lo && base == ADDR_PERIOD) begin
            period <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sleep_val <= 9'h000;
        end else if (ce && reg_wr && base == ADDR_SLEEP) begin
            if (reg_addr[0]) begin
                sleep_val[8] <= reg_wdata[SLEEP_FOREVER_BIT];
            end else begin
                sleep_val[7:0] <= reg_wdata;
            end
        end
    end

    assign tif.period        = period;
    assign tif.ext_mode      = ~gpio_dir[EXT_CLK_LINE] & (period == EXT_CLK_PERIOD);
    assign tif.ext_edge      = l4_sync[1] & ~l4_prev;
    assign tif.sleep_forever = ce & wr_hi & (base == ADDR_SLEEP) & reg_wdata[SLEEP_FOREVER_BIT];
    assign tif.sleep_load    = ce & wr_lo & (base == ADDR_SLEEP);
    assign tif.sleep_count   = reg_wdata;
    assign tif.wake          = ~cs_sync[1] & cs_prev;

    icb_sample_timer #(
        .TB_FAST  (TB_FAST),
        .TB_SLOW  (TB_SLOW),
        .HALF_SEC (HALF_SEC)
    ) u_timer (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .t      (tif)
    );

    assign sample_tick = tif.sample_tick;
    assign sleeping    = tif.sleeping;
    assign low_power   = (period >= LOW_POWER_MIN);

    // ========================================================
    // Range and filter
    // The filter byte is clamped against the range held at the time, so a
    // range written afterwards re-clamps the stored exponent as well.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            range_sel <= RST_RANGE;
            filt      <= RST_FILTER;
        end else if (ce && reg_wr && base == ADDR_RANGE) begin
            if (reg_addr[0]) begin
                range_sel <= reg_wdata[2:0];
                filt      <= clamp_exp(reg_wdata[2:0], filt);
            end else begin
                filt <= clamp_exp(range_sel, reg_wdata[2:0]);
            end
        end
    end

    assign gyro_range = range_sel;
    assign filter_exp = filt;

    // ========================================================
    // General I/O register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gpio_dir   <= 4'h0;
            gpio_level <= 4'h0;
        end else if (ce && reg_wr && base == ADDR_GPIO) begin
            if (reg_addr[0]) begin
                gpio_level <= reg_wdata[3:0];
            end else begin
                gpio_dir <= reg_wdata[3:0];
            end
        end
    end

    // ========================================================
    // Miscellaneous control
    // A write wins over a completion in the same cycle, so a new start is
    // never lost behind the end of the previous test.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            misc            <= RST_MISC;
            self_test_start <= 1'b0;
            mem_test_start  <= 1'b0;
        end else if (ce) begin
            self_test_start <= 1'b0;
            mem_test_start  <= 1'b0;
            if (self_test_done) begin
                misc[MISC_SELF_TEST] <= 1'b0;
            end
            if (mem_test_done) begin
                misc[MISC_MEM_TEST] <= 1'b0;
            end
            if (reg_wr && base == ADDR_MISC) begin
                if (reg_addr[0]) begin
                    misc[11:8]      <= reg_wdata[3:0];
                    self_test_start <= reg_wdata[MISC_SELF_TEST - 8];
                    mem_test_start  <= reg_wdata[MISC_MEM_TEST - 8];
                end else begin
                    misc[7:6] <= reg_wdata[7:6];
                    misc[2:0] <= reg_wdata[2:0];
                end
            end
        end
    end

    assign stim_neg        = misc[MISC_ST_NEG];
    assign stim_pos        = misc[MISC_ST_POS];
    assign bias_comp_en    = misc[MISC_BIAS];
    assign origin_align_en = misc[MISC_ORIGIN];

    // ========================================================
    // Data ready pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drdy_cnt <= 32'h0;
        end else if (ce) begin
            if (tif.sample_tick) begin
                drdy_cnt <= 32'(DRDY_LEN);
            end else if (drdy_cnt != 32'h0) begin
                drdy_cnt <= drdy_cnt - 32'h1;
            end
        end
    end

    assign drdy_pulse = (drdy_cnt != 32'h0);

    // ========================================================
    // Aux line drivers, highest priority first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aux_out <= 4'h0;
            aux_oe  <= 4'h0;
        end else if (ce) begin
            for (int i = 0; i < 4; i++) begin
                if (misc[MISC_DRDY_EN] && 32'(i) == 32'(misc[MISC_DRDY_LINE])) begin
                    aux_oe[i]  <= 1'b1;
                    aux_out[i] <= misc[MISC_DRDY_POL] ? drdy_pulse : ~drdy_pulse;
                end else if (alarm_en && 32'(i) == 32'(alarm_line)) begin
                    aux_oe[i]  <= 1'b1;
                    aux_out[i] <= alarm_level;
                end else begin
                    aux_oe[i]  <= gpio_dir[i];
                    aux_out[i] <= gpio_dir[i] & gpio_level[i];
                end
            end
        end
    end

    // ========================================================
    // DAC staging and latch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dac_stage <= 12'h000;
        end else if (ce && reg_wr && base == ADDR_DAC) begin
            if (reg_addr[0]) begin
                dac_stage[11:8] <= reg_wdata[3:0];
            end else begin
                dac_stage[7:0] <= reg_wdata;
            end
        end
    end

    // The command bit completes in the cycle of the write, so it never reads one.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dac_code <= 12'h000;
        end else if (ce && wr_lo && base == ADDR_GLOBAL && reg_wdata[GLOBAL_DAC_LATCH]) begin
            dac_code <= dac_stage;
        end
    end

    // ========================================================
    // Read back
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            if (base == ADDR_DAC) begin
                reg_rdata <= reg_addr[0] ? {4'h0, dac_stage[11:8]} : dac_stage[7:0];
            end else if (base == ADDR_GPIO) begin
                reg_rdata <= reg_addr[0] ? {4'h0, gpio_level} : {4'h0, gpio_dir};
            end else if (base == ADDR_MISC) begin
                reg_rdata <= reg_addr[0] ? misc[15:8] : misc[7:0];
            end else if (base == ADDR_PERIOD) begin
                reg_rdata <= reg_addr[0] ? 8'h00 : period;
            end else if (base == ADDR_RANGE) begin
                reg_rdata <= reg_addr[0] ? {5'h00, range_sel} : {5'h00, filt};
            end else if (base == ADDR_SLEEP) begin
                reg_rdata <= reg_addr[0] ? {7'h00, sleep_val[8]} : sleep_val[7:0];
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

endmodule

`default_nettype wire

// ### icb_host_model.sv
// Host side model: external sample clock and chip select.
`timescale 1ns/1ps
`default_nettype none

module icb_host_model (
    input  wire logic run,
    input  wire logic wake,
    output logic      ext_clk,
    output logic      cs_n
);
    // ========================================================
    // Host pins
    // The clock stands still low between frames, as a host clock does.
    initial begin
        ext_clk = 1'b0;
        forever #62.5 ext_clk = run ? ~ext_clk : 1'b0;
    end
    assign cs_n = ~wake;
endmodule

`default_nettype wire

// ### icb_config_bank_properties.sv
// Concurrent checks on the ports of the configuration bank.
`timescale 1ns/1ps
`default_nettype none

module icb_config_bank_properties
    import icb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        reg_wr,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        sample_tick,
    input  wire logic        sleeping,
    input  wire logic        low_power,
    input  wire logic [2:0]  gyro_range,
    input  wire logic [2:0]  filter_exp,
    input  wire logic        bias_comp_en,
    input  wire logic        origin_align_en,
    input  wire logic        stim_neg,
    input  wire logic        stim_pos,
    input  wire logic        self_test_start,
    input  wire logic        mem_test_start,
    input  wire logic [11:0] dac_code
);
    // ========================================================
    // Helpers
    logic wr_ok;
    logic latch_req;
    assign wr_ok = ce && reg_wr;
    assign latch_req = wr_ok && reg_addr == ADDR_GLOBAL && reg_wdata[GLOBAL_DAC_LATCH];
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    low_power_a: assert property (wr_ok && reg_addr == ADDR_PERIOD |=>
        low_power == ($past(reg_wdata) >= LOW_POWER_MIN)) else $error("low power flag wrong");
    self_start_a: assert property (wr_ok && reg_addr == (ADDR_MISC | 7'h01) && reg_wdata[2]
        |=> self_test_start ##1 !self_test_start) else $error("self-test start pulse wrong");
    mem_start_a: assert property (wr_ok && reg_addr == (ADDR_MISC | 7'h01) && reg_wdata[3]
        |=> mem_test_start ##1 !mem_test_start) else $error("memory test start pulse wrong");
    stim_bits_a: assert property (wr_ok && reg_addr == (ADDR_MISC | 7'h01) |=>
        {stim_neg, stim_pos} == $past(reg_wdata[1:0])) else $error("stimulus bits wrong");
    bias_bits_a: assert property (wr_ok && reg_addr == ADDR_MISC |=>
        {bias_comp_en, origin_align_en} == $past(reg_wdata[7:6])) else $error("bias bits wrong");
    dac_latch_a: assert property (!$stable(dac_code) |-> $past(latch_req))
        else $error("dac code moved without latch");
    quarter_min_a: assert property (gyro_range == RANGE_QUARTER |->
        filter_exp >= MIN_EXP_QUARTER) else $error("quarter range filter too small");
    half_min_a: assert property (gyro_range == RANGE_HALF |->
        filter_exp >= MIN_EXP_HALF) else $error("half range filter too small");
    filter_store_a: assert property (wr_ok && reg_addr == ADDR_RANGE && gyro_range == RST_RANGE
        |=> filter_exp == $past(reg_wdata[2:0])) else $error("filter exponent not stored");
    sleep_quiet_a: assert property (sleeping && $past(sleeping) |-> !sample_tick)
        else $error("sample tick while sleeping");
    unused_read_a: assert property (ce && reg_addr == (ADDR_PERIOD | 7'h01) |=>
        reg_rdata == 8'h00) else $error("unused byte reads nonzero");
    global_read_a: assert property (ce && reg_addr == ADDR_GLOBAL |=> reg_rdata == 8'h00)
        else $error("global command reads nonzero");
endmodule

bind icb_config_bank icb_config_bank_properties u_props (.clk, .resetn, .ce, .reg_wr, .reg_addr,
    .reg_wdata, .reg_rdata, .sample_tick, .sleeping, .low_power, .gyro_range, .filter_exp,
    .bias_comp_en, .origin_align_en, .stim_neg, .stim_pos, .self_test_start, .mem_test_start,
    .dac_code);

`default_nettype wire

// ### icb_config_bank_tb.sv
// Self-checking testbench for the configuration and control bank.
`timescale 1ns/1ps
`default_nettype none

module icb_config_bank_tb;
    import icb_pkg::*;
    logic        clk = 0, resetn = 0, reg_wr = 0, run = 0, wake = 0, st_done = 0, mt_done = 0;
    logic [6:0]  reg_addr = 0;
    logic [7:0]  reg_wdata = 0, reg_rdata;
    logic [3:0]  aux_out, aux_oe;
    logic [2:0]  gyro_range, filter_exp;
    logic [11:0] dac_code;
    logic        ce = 1, al_on = 0;
    logic        ext_clk, cs_n, sample_tick, sleeping, low_power, bias, origin, sn, sp, sts, mts;
    int          fail_count = 0, tests_run = 0, cycles = 0, edges = 0, n, k;

    // Short counts keep the run brief.
    icb_config_bank #(.TB_FAST(20), .TB_SLOW(40), .HALF_SEC(100), .DRDY_LEN(5)) dut (.clk,
        .resetn, .ce, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .cs_n,
        .aux_in({ext_clk, 3'h0}), .aux_out, .aux_oe, .alarm_en(al_on), .alarm_line(al_on),
        .alarm_level(al_on), .sample_tick, .sleeping, .low_power, .gyro_range, .filter_exp,
        .bias_comp_en(bias), .origin_align_en(origin), .stim_neg(sn), .stim_pos(sp),
        .self_test_start(sts), .self_test_done(st_done), .mem_test_start(mts),
        .mem_test_done(mt_done), .dac_code);
    icb_host_model host (.run, .wake, .ext_clk, .cs_n);

    // ========================================================
    // Common tasks
    always #4 clk = ~clk;
    always @(posedge ext_clk) edges++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            final_report;
        end
    end
    task cyc; @(posedge clk); #1; endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) cyc;
        d = reg_rdata;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (e !== s) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wait_tick(output int c);
        for (c = 1; c < 5000; c++) begin
            cyc;
            if (sample_tick === 1'b1) break;
        end
    endtask
    task act_len(input int ln, input logic lv, output int c);
        c = 0;
        wait_tick(k);
        repeat (24) begin
            cyc;
            if (aux_out[ln] === lv) c++;
        end
    endtask

    // ========================================================
    // Scenarios
    task t_reset;
        logic [6:0] a [6] = '{ADDR_MISC, ADDR_PERIOD, 7'h39, ADDR_RANGE, 7'h37, 7'h10};
        logic [7:0] e [6] = '{8'h06, 8'h01, 8'h04, 8'h02, 8'h00, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            rd(a[i], d);
            chk("reset_read", e[i], d);
        end
    endtask
    task t_period;
        wr(ADDR_PERIOD, 8'h03); wait_tick(n); wait_tick(n);
        chk("fast_period", 80, n);
        wr(ADDR_PERIOD, 8'h83); wait_tick(n); wait_tick(n);
        chk("slow_period", 160, n);
        chk("low_power", 1, low_power);
        wr(ADDR_PERIOD, 8'h09); cyc;
        chk("low_power_off", 0, low_power);
        wr(ADDR_PERIOD, 8'h03);
    endtask
    task t_ready;
        act_len(0, 1'b1, n);
        chk("ready_width", 5, n);
        wr(ADDR_GPIO, 8'h0f); wr(ADDR_MISC, 8'h04); act_len(0, 1'b0, n);
        chk("ready_low", 5, n);
        chk("ready_idle", 1, aux_out[0]);
        al_on <= 1; wr(ADDR_MISC, 8'h07); act_len(1, 1'b1, n);
        chk("ready_line2", 5, n);
        wr(ADDR_MISC, 8'h00); wr(ADDR_GPIO | 7'h01, 8'h0a); wr(ADDR_GPIO, 8'h0c);
        repeat (3) cyc;
        chk("gpio_levels", 8'hea, {aux_oe, aux_out});
    endtask
    task t_ext;
        wr(ADDR_GPIO, 8'h00); wr(ADDR_PERIOD, 8'h00);
        edges = 0; k = 0; run = 1;
        repeat (400) begin cyc; k += sample_tick; end
        run = 0;
        repeat (12) begin cyc; k += sample_tick; end
        chk("ext_ticks", edges, k);
        wr(ADDR_PERIOD, 8'h01);
    endtask
    task t_sleep;
        wr(ADDR_SLEEP, 8'h02); cyc;
        for (n = 0; n < 400 && sleeping === 1'b1; n++) cyc;
        chk("timed_sleep", 199, n);
        wr(ADDR_SLEEP | 7'h01, 8'h01); repeat (300) cyc;
        chk("sleep_hold", 1, sleeping);
        wake = 1; repeat (6) cyc;
        chk("sleep_wake", 0, sleeping);
        wake = 0;
    endtask
    task t_range;
        wr(ADDR_RANGE | 7'h01, 8'h01); wr(ADDR_RANGE, 8'h00); cyc;
        chk("quarter", {RANGE_QUARTER, MIN_EXP_QUARTER}, {gyro_range, filter_exp});
        wr(ADDR_RANGE | 7'h01, 8'h02); wr(ADDR_RANGE, 8'h01); cyc;
        chk("half", {RANGE_HALF, MIN_EXP_HALF}, {gyro_range, filter_exp});
        wr(ADDR_RANGE | 7'h01, 8'h04); wr(ADDR_RANGE, 8'hfe); cyc;
        chk("full", 6'h26, {gyro_range, filter_exp});
    endtask
    task t_tests;
        logic [7:0] d;
        wr(ADDR_MISC | 7'h01, 8'h04); rd(ADDR_MISC | 7'h01, d);
        chk("self_set", 8'h04, d);
        st_done <= 1; cyc; st_done <= 0; rd(ADDR_MISC | 7'h01, d);
        chk("self_clear", 8'h00, d);
        wr(ADDR_MISC | 7'h01, 8'h08); mt_done <= 1; cyc; mt_done <= 0; rd(ADDR_MISC | 7'h01, d);
        chk("mem_clear", 8'h00, d);
        wr(ADDR_MISC | 7'h01, 8'hf3); wr(ADDR_MISC, 8'hff); rd(ADDR_MISC | 7'h01, d);
        chk("stim_read", {8'h03, 4'hf}, {d, sn, sp, bias, origin});
        wr(ADDR_MISC | 7'h01, 8'h00);
    endtask
    task t_dac;
        logic [7:0] d;
        wr(ADDR_DAC, 8'hd9); wr(ADDR_DAC | 7'h01, 8'hf4); ce <= 0; wr(ADDR_GLOBAL, 8'h04); cyc;
        chk("dac_staged", 0, dac_code);
        ce <= 1; wr(ADDR_GLOBAL, 8'h04); cyc;
        chk("dac_latched", 12'h4d9, dac_code);
        rd(ADDR_DAC | 7'h01, d);
        chk("dac_upper", 8'h04, d);
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset; t_period; t_ready; t_ext; t_sleep; t_range; t_tests; t_dac;
        final_report;
    end
endmodule

`default_nettype wire
